// *** i2cfs_pkg.sv ***
// shared constants and types for the fast-mode i2c target port
package i2cfs_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_SU_DAT_NS = 100;
  localparam int SU_CYC = (T_SU_DAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SU_CNT_W = 3;
  localparam int STRETCH_MAX_MS = 20;
  localparam int STRETCH_MAX_CYC = (STRETCH_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int BIT_CNT_W = 3;
  // target address default, value is arbitrary
  localparam logic [6:0] OWN_ADDR_DFLT = 7'h2a;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR_DATA  = 7'h08,
    ST_WR_ACK   = 7'h10,
    ST_RD_DATA  = 7'h20,
    ST_RD_ACK   = 7'h40
  } i2cfs_state_t;
endpackage : i2cfs_pkg

// *** i2cfs_stretch_wdog.sv ***
// watchdog that bounds one clock-stretch episode
`timescale 1ns/1ps
module i2cfs_stretch_wdog #(
  parameter int MAX_CYC = 1000000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // control
  input wire logic run_i,
  output logic expire_o
);
  localparam int CW = $clog2(MAX_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(MAX_CYC - 1);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
    end else if (!run_i) begin
      cnt_reg <= '0;
    end else if (cnt_reg != LAST) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign expire_o = run_i && (cnt_reg == LAST);
endmodule : i2cfs_stretch_wdog

// *** i2cfs_port.sv ***
// fast-mode i2c target port with clock stretching and byte streams
`timescale 1ns/1ps
module i2cfs_port
  import i2cfs_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = OWN_ADDR_DFLT,
  parameter int STRETCH_CYC = STRETCH_MAX_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // interface-select strap, high selects i2c, low selects spi
  input wire logic iface_sel_i,
  output logic pins_spi_o,
  // i2c clock line
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  // i2c data line
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // bytes written by the master
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  // bytes read by the master
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  i2cfs_state_t state_reg;
  logic scl_q_reg, sda_q_reg;
  logic [7:0] sh_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic got8_reg, rw_reg, acked_reg;
  logic sda_oe_reg, scl_oe_reg;
  logic [SU_CNT_W-1:0] su_cnt_reg;
  logic [7:0] rx_data_reg;
  logic rx_valid_reg;
  logic pins_spi_reg;
  logic en, scl_rise, scl_fall, start_det, stop_det;
  logic su_busy, ready_now, act_now, wd_expire, load_evt;
  logic wr_done, stretch_start, push, take;
  logic [7:0] rd_byte;

  // edge and condition detection on the sampled lines
  assign en = iface_sel_i;
  assign scl_rise = scl_i && !scl_q_reg;
  assign scl_fall = !scl_i && scl_q_reg;
  assign start_det = scl_i && scl_q_reg && sda_q_reg && !sda_i;
  assign stop_det = scl_i && scl_q_reg && !sda_q_reg && sda_i;

  // stretch bookkeeping
  assign su_busy = (su_cnt_reg != '0);
  assign ready_now = rw_reg ? tx_valid_i : !rx_valid_reg;
  assign act_now = en && scl_oe_reg && !su_busy &&
                   (ready_now || wd_expire);
  assign rd_byte = ready_now ? tx_data_i : FILL_BYTE;
  assign load_evt = en && scl_fall && !start_det && !stop_det &&
                    (((state_reg == ST_ADDR_ACK) && rw_reg) ||
                     ((state_reg == ST_RD_ACK) && acked_reg));
  assign wr_done = en && scl_fall && !start_det && !stop_det && got8_reg &&
                   (state_reg == ST_WR_DATA);
  assign stretch_start = (wr_done && rx_valid_reg) ||
                         (load_evt && !tx_valid_i);
  assign push = (wr_done && !rx_valid_reg) ||
                (act_now && !rw_reg && ready_now);
  assign take = (load_evt && tx_valid_i) ||
                (act_now && rw_reg && ready_now);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_i;
      sda_q_reg <= sda_i;
    end
  end

  // pin routing indication
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pins_spi_reg <= 1'b0;
    end else begin
      pins_spi_reg <= !iface_sel_i;
    end
  end

  // protocol engine, target only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      sh_reg <= BYTE_RST;
      bit_cnt_reg <= '0;
      got8_reg <= 1'b0;
      rw_reg <= 1'b0;
      acked_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (!en || stop_det) begin
      state_reg <= ST_IDLE;
      got8_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= '0;
      got8_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (act_now) begin
      if (rw_reg) begin
        sh_reg <= rd_byte;
        sda_oe_reg <= !rd_byte[7];
      end else begin
        sda_oe_reg <= ready_now;
      end
    end else begin
      case (state_reg)
        ST_ADDR, ST_WR_DATA: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_i};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            got8_reg <= (bit_cnt_reg == LAST_BIT);
          end else if (scl_fall && got8_reg) begin
            got8_reg <= 1'b0;
            if (state_reg == ST_WR_DATA) begin
              state_reg <= ST_WR_ACK;
              sda_oe_reg <= !rx_valid_reg;
            end else if (sh_reg[7:1] == OWN_ADDR) begin
              state_reg <= ST_ADDR_ACK;
              rw_reg <= sh_reg[0];
              sda_oe_reg <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= '0;
            if (rw_reg) begin
              state_reg <= ST_RD_DATA;
              sh_reg <= tx_data_i;
              sda_oe_reg <= tx_valid_i && !tx_data_i[7];
            end else begin
              state_reg <= ST_WR_DATA;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            state_reg <= ST_WR_DATA;
            bit_cnt_reg <= '0;
            sda_oe_reg <= 1'b0;
          end
        end
        ST_RD_DATA: begin
          if (scl_fall) begin
            if (bit_cnt_reg == LAST_BIT) begin
              state_reg <= ST_RD_ACK;
              sda_oe_reg <= 1'b0;
            end else begin
              sh_reg <= {sh_reg[6:0], 1'b0};
              sda_oe_reg <= !sh_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            acked_reg <= !sda_i;
          end else if (scl_fall) begin
            bit_cnt_reg <= '0;
            if (acked_reg) begin
              state_reg <= ST_RD_DATA;
              sh_reg <= tx_data_i;
              sda_oe_reg <= tx_valid_i && !tx_data_i[7];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // clock stretch and set-up countdown before release
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_oe_reg <= 1'b0;
      su_cnt_reg <= '0;
    end else if (!en) begin
      scl_oe_reg <= 1'b0;
      su_cnt_reg <= '0;
    end else if (stretch_start) begin
      scl_oe_reg <= 1'b1;
    end else if (act_now) begin
      su_cnt_reg <= SU_CNT_W'(SU_CYC);
    end else if (su_busy) begin
      su_cnt_reg <= su_cnt_reg - 1'b1;
      if (su_cnt_reg == SU_CNT_W'(1)) begin
        scl_oe_reg <= 1'b0;
      end
    end
  end

  // received byte holding register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_data_reg <= BYTE_RST;
      rx_valid_reg <= 1'b0;
    end else if (push) begin
      rx_data_reg <= sh_reg;
      rx_valid_reg <= 1'b1;
    end else if (rx_ready_i) begin
      rx_valid_reg <= 1'b0;
    end
  end

  i2cfs_stretch_wdog #(
    .MAX_CYC(STRETCH_CYC)
  ) u_wdog (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .run_i(scl_oe_reg && !su_busy),
    .expire_o(wd_expire)
  );

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_oe_reg;
  assign sda_oe_o = sda_oe_reg;
  assign rx_data_o = rx_data_reg;
  assign rx_valid_o = rx_valid_reg;
  assign tx_ready_o = take;
  assign pins_spi_o = pins_spi_reg;

  // checks
  logic [31:0] hold_cnt_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_cnt_reg <= '0;
    end else if (scl_oe_reg) begin
      hold_cnt_reg <= hold_cnt_reg + 32'h1;
    end else begin
      hold_cnt_reg <= '0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_target_only: assert property ($rose(scl_oe_o) |-> !scl_i)
    else $error("scl pulled low while the line was high");
  chk_idle_quiet: assert property (state_reg == ST_IDLE && !act_now
      |=> !sda_oe_o || state_reg != ST_IDLE)
    else $error("sda driven while idle");
  chk_read_stretch: assert property (disable iff (!rstn_i || !en)
      load_evt && !tx_valid_i |=> scl_oe_o)
    else $error("no stretch when read byte missing");
  chk_stretch_bound: assert property (hold_cnt_reg <=
      32'(STRETCH_CYC) + 32'(SU_CYC) + 32'h2)
    else $error("clock stretch too long");
  chk_setup_hold: assert property (disable iff (!rstn_i || !en)
      act_now |=> scl_oe_o [*5] ##1 !scl_oe_o)
    else $error("scl released without set-up time");
  chk_setup_sda: assert property (disable iff (!rstn_i || !en)
      act_now |=> ##1 $stable(sda_oe_o) [*5])
    else $error("sda moved before scl release");
  chk_strap_off: assert property (!iface_sel_i
      |=> !scl_oe_o && !sda_oe_o && state_reg == ST_IDLE)
    else $error("port active with spi selected");
  chk_pin_route: assert property (##1 pins_spi_o == !$past(en))
    else $error("pin routing does not follow strap");
  chk_rx_stream: assert property (push
      |=> rx_valid_o && rx_data_o == $past(sh_reg))
    else $error("received byte not presented");
  chk_prompt_free: assert property (disable iff (!rstn_i || !en)
      scl_oe_reg && !su_busy && ready_now |=> su_busy)
    else $error("stretch kept although byte ready");

  cov_write_ack: cover property (wr_done && !rx_valid_reg);
  cov_read_load: cover property (load_evt && tx_valid_i);
  cov_stretch_rel: cover property (act_now ##6 !scl_oe_o);
  cov_timeout: cover property (wd_expire);
endmodule : i2cfs_port

// *** i2cfs_master_model.sv ***
// behavioural fast-mode i2c bus master driving the target port
`timescale 1ns/1ps
module i2cfs_master_model (
  // clock
  input wire logic clk_i,
  // resolved bus levels
  input wire logic scl_i,
  input wire logic sda_i,
  // high pulls the line low
  output logic scl_low_o,
  output logic sda_low_o
);
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // 65 cycles low, 60 high: 2.5 us per bit, 400 kbit/s
  task automatic clk_bit(input logic b, output logic s);
    cyc(5);
    sda_low_o <= !b;
    cyc(60);
    scl_low_o <= 1'b0;
    do cyc(1); while (scl_i !== 1'b1);
    cyc(30);
    s = sda_i;
    cyc(30);
    scl_low_o <= 1'b1;
  endtask : clk_bit

  task automatic start();
    sda_low_o <= 1'b1;
    cyc(30);
    scl_low_o <= 1'b1;
  endtask : start

  task automatic stop();
    cyc(5);
    sda_low_o <= 1'b1;
    cyc(60);
    scl_low_o <= 1'b0;
    cyc(30);
    sda_low_o <= 1'b0;
    cyc(65);
  endtask : stop

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask : write_byte

  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(nack, s);
  endtask : read_byte
endmodule : i2cfs_master_model

// *** i2cfs_port_tb.sv ***
// self-checking testbench for the fast-mode i2c target port
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module i2cfs_port_tb;
  import i2cfs_pkg::*;
  localparam int ST_CYC = 400;
  logic clk, rstn, iface_sel;
  logic scl_w, sda_w, m_scl, m_sda, scl_o, sda_o, scl_oe, sda_oe, pins_spi;
  logic [7:0] rx_data, tx_data, d;
  logic rx_valid, rx_ready, tx_valid, tx_ready, ack;
  logic sda_q = 1'b0, scl_q = 1'b0;
  logic [3:0] takes = 4'h0;
  int failures = 0, compares = 0, su_len = 0, st_len = 0;

  initial clk = 1'b0;
  always #10 clk = ~clk;
  assign scl_w = !(m_scl | scl_oe);
  assign sda_w = !(m_sda | sda_oe);

  i2cfs_port #(.STRETCH_CYC(ST_CYC)) u_dut (.clk_i(clk), .rstn_i(rstn),
    .iface_sel_i(iface_sel), .pins_spi_o(pins_spi), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready));
  i2cfs_master_model u_mst (.clk_i(clk), .scl_i(scl_w), .sda_i(sda_w),
    .scl_low_o(m_scl), .sda_low_o(m_sda));

  // stretch length and data set-up before each scl release
  always @(posedge clk) begin
    sda_q <= sda_oe;
    scl_q <= scl_oe;
    su_len <= (sda_oe !== sda_q) ? 0 : su_len + 1;
    st_len <= scl_oe ? st_len + 1 : 0;
    takes <= takes + {3'h0, tx_ready};
    if (scl_q && !scl_oe) begin
      `CHK(st_len <= ST_CYC + 6, 1'b1)
      `CHK(su_len + 1 >= SU_CYC, 1'b1)
    end
  end

  task automatic complete_run();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic test_write();
    u_mst.start();
    u_mst.write_byte({OWN_ADDR_DFLT, 1'b0}, ack);
    `CHK(ack, 1'b1)
    u_mst.write_byte(8'ha5, ack);
    `CHK(ack, 1'b1)
    `CHK(rx_valid, 1'b1)
    `CHK(rx_data, 8'ha5)
    fork
      u_mst.write_byte(8'h5a, ack);
      begin
        wait (scl_oe === 1'b1);
        u_mst.cyc(100);
        `CHK(scl_oe, 1'b1)
        rx_ready <= 1'b1;
        u_mst.cyc(1);
        rx_ready <= 1'b0;
      end
    join
    `CHK(ack, 1'b1)
    `CHK(rx_data, 8'h5a)
    `CHK(scl_o, 1'b0)
    `CHK(sda_o, 1'b0)
    u_mst.write_byte(8'h77, ack);
    `CHK(ack, 1'b0)
    `CHK(rx_data, 8'h5a)
    u_mst.stop();
    rx_ready <= 1'b1;
    $display("test_write done");
  endtask : test_write

  task automatic test_bad_addr();
    u_mst.start();
    u_mst.write_byte({7'h15, 1'b0}, ack);
    `CHK(ack, 1'b0)
    u_mst.stop();
    $display("test_bad_addr done");
  endtask : test_bad_addr

  task automatic test_read();
    tx_data <= 8'h3c;
    tx_valid <= 1'b1;
    u_mst.start();
    u_mst.write_byte({OWN_ADDR_DFLT, 1'b1}, ack);
    `CHK(ack, 1'b1)
    u_mst.read_byte(1'b1, d);
    `CHK(d, 8'h3c)
    `CHK(takes, 4'h1)
    tx_valid <= 1'b0;
    u_mst.stop();
    $display("test_read done");
  endtask : test_read

  task automatic test_read_stretch();
    u_mst.start();
    u_mst.write_byte({OWN_ADDR_DFLT, 1'b1}, ack);
    fork
      u_mst.read_byte(1'b0, d);
      begin
        wait (scl_oe === 1'b1);
        u_mst.cyc(100);
        `CHK(scl_oe, 1'b1)
        tx_data <= 8'hc3;
        tx_valid <= 1'b1;
        do u_mst.cyc(1); while (tx_ready !== 1'b1);
        tx_valid <= 1'b0;
      end
    join
    `CHK(d, 8'hc3)
    `CHK(takes, 4'h2)
    u_mst.read_byte(1'b1, d);
    `CHK(d, FILL_BYTE)
    `CHK(takes, 4'h2)
    u_mst.stop();
    $display("test_read_stretch done");
  endtask : test_read_stretch

  task automatic test_strap();
    iface_sel <= 1'b0;
    u_mst.cyc(3);
    `CHK(pins_spi, 1'b1)
    u_mst.start();
    u_mst.write_byte({OWN_ADDR_DFLT, 1'b0}, ack);
    `CHK(ack, 1'b0)
    u_mst.stop();
    iface_sel <= 1'b1;
    u_mst.cyc(3);
    `CHK(pins_spi, 1'b0)
    $display("test_strap done");
  endtask : test_strap

  initial begin
    rstn = 1'b0;
    iface_sel = 1'b1;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    u_mst.cyc(5);
    test_write();
    test_bad_addr();
    test_read();
    test_read_stretch();
    test_strap();
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule : i2cfs_port_tb
